// >>> mis_defs.svh
`ifndef MIS_DEFS_SVH
`define MIS_DEFS_SVH

// Timing
`define MIS_CLK_HZ 25000000
`define MIS_ARRAY_TIME_MS 25
`define MIS_ARRAY_CYCLES ((`MIS_CLK_HZ / 1000) * `MIS_ARRAY_TIME_MS)

// Register offsets, and the adr_i[7:5] value that selects the table
`define MIS_ADDR_CTRL 8'h00
`define MIS_ADDR_STATUS 8'h04
`define MIS_ADDR_IRQ_STAT 8'h08
`define MIS_ADDR_IRQ_MASK 8'h0C
`define MIS_ADDR_TABLE 3'h1

// Control fields
`define MIS_CTRL_EN 0
`define MIS_CTRL_NUM_LSB 4
`define MIS_CTRL_SEL_LSB 8
`define MIS_CTRL_TBL_LSB 12
`define MIS_CTRL_RST 32'h0000_0070

// Status fields
`define MIS_STAT_BUSY 0
`define MIS_STAT_IDX_LSB 4

// Interrupt bits
`define MIS_IRQ_DONE 0

`endif

// >>> mis_matrix.sv
`timescale 1ns/1ps
`default_nettype none

module mis_matrix (
    input wire logic [7:0] select_i,
    input wire logic [63:0] sw_i,
    output logic [7:0] sense_o
);
    // selected array only
    // Unselected rows float, pull-downs read open
    always_comb begin
        sense_o = 8'h00;
        for (int j = 0; j < 8; j++) begin
            if (select_i[j]) begin
                sense_o = sense_o | sw_i[8*j +: 8];
            end
        end
    end
endmodule

`default_nettype wire

// >>> mis_mem.sv
`timescale 1ns/1ps
`default_nettype none

module mis_mem (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [2:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [7:0] rdata_o
);

    logic [7:0] row [8];

    // Registered read port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            row[waddr_i] <= wdata_i;
        end
        rdata_o <= row[raddr_i];
    end

endmodule

`default_nettype wire

// >>> mis_pkg.sv
package mis_pkg;

    typedef enum logic [1:0] {
        mis_idle = 2'h0,
        mis_drive = 2'h1,
        mis_cap = 2'h3,
        mis_gap = 2'h2
    } mis_state_e;

    typedef logic [2:0] mis_idx_t;

endpackage

// >>> mis_scanner.sv
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defs.svh"

module mis_scanner
    import mis_pkg::*;
#(
    parameter int ARRAY_CYCLES = `MIS_ARRAY_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] sense_i,
    output logic [7:0] select_o,
    output logic scan_done_o,
    output logic irq_o
);

    logic [7:0] sense_m;
    logic [7:0] sense_s;
    logic tick;
    logic en;
    logic [7:0] rdata;

    mis_state_e st, next_st;
    mis_idx_t idx, next_idx;
    mis_idx_t last, next_last;
    mis_idx_t sel_head, next_sel_head;
    mis_idx_t tbl_head, next_tbl_head;
    logic [7:0] next_sel;
    logic next_done;
    logic mem_we;
    mis_idx_t mem_waddr;

    logic [31:0] ctrl, next_ctrl;
    logic irq_stat, next_irq_stat;
    logic irq_mask, next_irq_mask;
    logic wb_wait, next_wb_wait;
    logic next_ack;
    logic [31:0] next_dat;
    logic [31:0] wmask;
    logic wr;

    function automatic logic [7:0] onehot(input mis_idx_t s);
        onehot = 8'h01 << s;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_m <= 8'h00;
            sense_s <= 8'h00;
        end else begin
            sense_m <= sense_i;
            sense_s <= sense_m;
        end
    end

    mis_tick #(
        .LEN(ARRAY_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(st != mis_drive),
        .tick_o(tick)
    );

    mis_mem u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(sense_s),
        .raddr_i(adr_i[4:2]),
        .rdata_o(rdata)
    );

    assign en = ctrl[`MIS_CTRL_EN];
    assign mem_waddr = tbl_head + idx;

    always_comb begin
        next_st = st;
        next_idx = idx;
        next_last = last;
        next_sel_head = sel_head;
        next_tbl_head = tbl_head;
        next_sel = 8'h00;
        next_done = 1'b0;
        mem_we = 1'b0;
        if (!en) begin
            next_st = mis_idle;
        end else begin
            case (st)
                mis_idle: begin
                    next_st = mis_drive;
                    next_idx = 3'h0;
                    // count field is arrays minus one
                    next_last = ctrl[`MIS_CTRL_NUM_LSB +: 3];
                    next_sel_head = ctrl[`MIS_CTRL_SEL_LSB +: 3];
                    next_tbl_head = ctrl[`MIS_CTRL_TBL_LSB +: 3];
                    next_sel = onehot(ctrl[`MIS_CTRL_SEL_LSB +: 3]);
                end
                mis_drive: begin
                    next_sel = select_o;
                    if (tick) begin
                        next_st = mis_cap;
                    end
                end
                mis_cap: begin
                    mem_we = 1'b1;
                    next_st = mis_gap;
                end
                mis_gap: begin
                    next_st = mis_drive;
                    if (idx == last) begin
                        next_done = 1'b1;
                        next_idx = 3'h0;
                        next_last = ctrl[`MIS_CTRL_NUM_LSB +: 3];
                        next_sel_head = ctrl[`MIS_CTRL_SEL_LSB +: 3];
                        next_tbl_head = ctrl[`MIS_CTRL_TBL_LSB +: 3];
                        next_sel = onehot(ctrl[`MIS_CTRL_SEL_LSB +: 3]);
                    end else begin
                        next_idx = idx + 3'h1;
                        next_sel = onehot(sel_head + idx + 3'h1);
                    end
                end
                default: begin
                    next_st = mis_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= mis_idle;
            idx <= 3'h0;
            last <= 3'h0;
            sel_head <= 3'h0;
            tbl_head <= 3'h0;
            select_o <= 8'h00;
            scan_done_o <= 1'b0;
        end else begin
            st <= next_st;
            idx <= next_idx;
            last <= next_last;
            sel_head <= next_sel_head;
            tbl_head <= next_tbl_head;
            select_o <= next_sel;
            scan_done_o <= next_done;
        end
    end

    // Wishbone slave and registers
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                    {8{sel_i[0]}}};
    assign wr = ack_o && cyc_i && stb_i && we_i;

    always_comb begin
        next_wb_wait = cyc_i && stb_i && !ack_o && !wb_wait;
        next_ack = cyc_i && stb_i && wb_wait;
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_dat = 32'h0000_0000;
        if (wr && adr_i == `MIS_ADDR_CTRL) begin
            next_ctrl = (ctrl & ~wmask) | (dat_i & wmask);
        end
        if (wr && adr_i == `MIS_ADDR_IRQ_MASK && sel_i[0]) begin
            next_irq_mask = dat_i[`MIS_IRQ_DONE];
        end
        if (wr && adr_i == `MIS_ADDR_IRQ_STAT && sel_i[0]
                && dat_i[`MIS_IRQ_DONE]) begin
            next_irq_stat = 1'b0;
        end
        if (scan_done_o) begin
            next_irq_stat = 1'b1;
        end
        if (wb_wait && !we_i) begin
            if (adr_i[7:5] == `MIS_ADDR_TABLE && adr_i[1:0] == 2'h0) begin
                next_dat = {24'h00_0000, rdata};
            end else begin
                case (adr_i)
                    `MIS_ADDR_CTRL: begin
                        next_dat = ctrl;
                    end
                    `MIS_ADDR_STATUS: begin
                        next_dat[`MIS_STAT_BUSY] = (st != mis_idle);
                        next_dat[`MIS_STAT_IDX_LSB +: 3] = idx;
                    end
                    `MIS_ADDR_IRQ_STAT: begin
                        next_dat[`MIS_IRQ_DONE] = irq_stat;
                    end
                    `MIS_ADDR_IRQ_MASK: begin
                        next_dat[`MIS_IRQ_DONE] = irq_mask;
                    end
                    default: begin
                        next_dat = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `MIS_CTRL_RST;
            irq_stat <= 1'b0;
            irq_mask <= 1'b0;
            wb_wait <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            wb_wait <= next_wb_wait;
            ack_o <= next_ack;
            dat_o <= next_dat;
            irq_o <= next_irq_stat && next_irq_mask;
        end
    end

    // Helper for period check
    logic [19:0] drive_len, next_drive_len;
    always_comb begin
        next_drive_len = 20'h0_0000;
        if (st == mis_drive) begin
            next_drive_len = drive_len + 20'h0_0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_len <= 20'h0_0000;
        end else begin
            drive_len <= next_drive_len;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_one_select: assert property ($onehot0(select_o))
        else $error("More than one select active");
    a_select_gap: assert property (
        ($changed(select_o) && select_o != 8'h00) |->
            $past(select_o) == 8'h00)
        else $error("Select moved without gap");
    a_select_pin: assert property (
        st == mis_drive |-> select_o == onehot(sel_head + idx))
        else $error("Wrong select for array");
    a_order_up: assert property (
        (st == mis_drive && $past(st) == mis_gap && $past(idx) != last)
            |-> idx == $past(idx) + 3'h1)
        else $error("Arrays not ascending");
    a_wrap_first: assert property (
        (st == mis_gap && idx == last && en) |=>
            (st == mis_drive && idx == 3'h0))
        else $error("Pass did not restart");
    a_capture_row: assert property (
        mem_we |-> select_o == onehot(sel_head + idx))
        else $error("Capture outside active array");
    a_done_pulse: assert property (
        $rose(scan_done_o) |=> !scan_done_o)
        else $error("Done flag longer than one cycle");
    a_done_cause: assert property (
        scan_done_o |-> $past(st) == mis_gap && $past(idx) == $past(last))
        else $error("Done without finished pass");
    a_array_time: assert property (
        (st == mis_cap && $past(st) == mis_drive) |->
            $past(drive_len) == 20'(ARRAY_CYCLES - 1))
        else $error("Array period wrong");
    a_disabled_off: assert property (
        $past(!en) |-> select_o == 8'h00 && !mem_we)
        else $error("Select active while disabled");

endmodule

`default_nettype wire

// >>> mis_tick.sv
`timescale 1ns/1ps
`default_nettype none

module mis_tick #(
    parameter int LEN = 625000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    output logic tick_o
);

    localparam int CW = $clog2(LEN + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic at_end;

    assign at_end = (cnt == CW'(LEN - 1));
    assign tick_o = !clr_i && at_end;

    always_comb begin
        if (clr_i || at_end) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mis_defs.svh"

module tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00, sense, select_o;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o, q;
    logic ack_o, scan_done_o, irq_o, prev_done = 0;
    logic [63:0] sw = 64'h0000_0000_0000_0000;
    logic [7:0] sel_q[$];
    int err_count = 0, tests_run = 0, cycles = 0, done_cnt = 0;
    int multi_sel = 0, long_done = 0;

    always #20 clk_i = ~clk_i;

    mis_scanner #(.ARRAY_CYCLES(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .sense_i(sense),
        .select_o(select_o), .scan_done_o(scan_done_o), .irq_o(irq_o));
    mis_matrix mtx_u (.select_i(select_o), .sw_i(sw), .sense_o(sense));

    task conclude;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            err_count = err_count + 1;
            conclude();
        end
        if (!rst_i) begin
            if ($countones(select_o) > 1) multi_sel <= multi_sel + 1;
            if (select_o != 8'h00 && select_o !== sel_q[$])
                sel_q.push_back(select_o);
            if (scan_done_o === 1'b1) done_cnt <= done_cnt + 1;
            if (scan_done_o === 1'b1 && prev_done) long_done <= 1;
            prev_done <= scan_done_o;
        end
    end

    task check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wait_done;
        int t, n;
        t = done_cnt + 1;
        n = 0;
        while (done_cnt < t && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        check("done seen", done_cnt >= t, 32'h1);
    endtask

    task t_reset;
        wb(0, `MIS_ADDR_CTRL, 0);
        check("ctrl reset", q, `MIS_CTRL_RST);
        check("select idle", select_o, 8'h00);
        wb(0, 8'h10, 0);
        check("unmapped", q, 32'h0000_0000);
        $display("test reset finished");
    endtask

    task t_wrap;
        sw <= 64'h8877_6655_4433_2211;
        sel_q.delete();
        wb(1, `MIS_ADDR_CTRL, 32'h0000_2711);
        wait_done();
        wb(1, `MIS_ADDR_CTRL, 32'h0000_0000);
        check("first select", sel_q[0], 8'h80);
        check("second select", sel_q[1], 8'h01);
        repeat (2) @(posedge clk_i);
        check("disabled select", select_o, 8'h00);
        wb(0, 8'h28, 0);
        check("row 2", q, 32'h0000_0088);
        wb(0, 8'h2C, 0);
        check("row 3", q, 32'h0000_0011);
        sw <= ~sw;
        repeat (40) @(posedge clk_i);
        wb(0, 8'h28, 0);
        check("row 2 held", q, 32'h0000_0088);
        $display("test wrap finished");
    endtask

    task t_full;
        sw <= 64'h0f1e_2d3c_4b5a_6978;
        // table head on a row boundary
        wb(1, `MIS_ADDR_CTRL, 32'h0000_0071);
        wait_done();
        wb(0, `MIS_ADDR_STATUS, 0);
        check("status busy", q[0], 1'b1);
        for (int k = 0; k < 8; k++) begin
            wb(0, 8'h20 + 8'(4 * k), 0);
            check("row full", q, {24'h00_0000, sw[8*k +: 8]});
        end
        sw <= ~sw;
        wait_done();
        wait_done();
        for (int k = 0; k < 8; k++) begin
            wb(0, 8'h20 + 8'(4 * k), 0);
            check("row refresh", q, {24'h00_0000, sw[8*k +: 8]});
        end
        wb(1, `MIS_ADDR_CTRL, 32'h0000_0000);
        $display("test full finished");
    endtask

    task t_irq;
        wb(0, `MIS_ADDR_STATUS, 0);
        check("status idle", q[0], 1'b0);
        wb(1, `MIS_ADDR_IRQ_MASK, 0);
        wb(0, `MIS_ADDR_IRQ_STAT, 0);
        check("stat sticky", q, 32'h0000_0001);
        check("irq masked", irq_o, 1'b0);
        wb(1, `MIS_ADDR_IRQ_MASK, 1);
        repeat (2) @(negedge clk_i);
        check("irq on", irq_o, 1'b1);
        wb(1, `MIS_ADDR_IRQ_STAT, 1);
        repeat (2) @(negedge clk_i);
        check("irq cleared", irq_o, 1'b0);
        check("one hot", multi_sel, 0);
        check("done width", long_done, 0);
        $display("test irq finished");
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_wrap();
        t_full();
        t_irq();
        conclude();
    end
endmodule

`default_nettype wire
